// ===== design/iasc_consts.vh
// constants for the indirect access and self-test control block
`ifndef IASC_CONSTS_VH
`define IASC_CONSTS_VH
`define IASC_IDX_CTL        8'hb0
`define IASC_IDX_OFS        8'hb1
`define IASC_IDX_DATA       8'hb2
`define IASC_IDX_BIST       8'hb3
`define IASC_IDX_SP4        8'hb4
`define IASC_IDX_SP5        8'hb5
`define IASC_IDX_SP6        8'hb6
`define IASC_IDX_SP7        8'hb7
`define IASC_IDX_STS        8'hc0
`define IASC_RST_CTL        8'h00
`define IASC_RST_OFS        8'h00
`define IASC_RST_DATA       8'h00
`define IASC_RST_BIST       8'h08
`define IASC_RST_SP4        8'h25
`define IASC_RST_SP5        8'h00
`define IASC_RST_SP6        8'h18
`define IASC_RST_SP7        8'h00
`define IASC_CTL_SEL_HI     5
`define IASC_CTL_SEL_LO     2
`define IASC_CTL_AINC       1
`define IASC_CTL_PREF       0
`define IASC_CTL_MASK       8'h3f
`define IASC_SEL_PATGEN     4'h0
`define IASC_SEL_RX0        4'h1
`define IASC_SEL_RX1        4'h2
`define IASC_SEL_RXSH       4'h5
`define IASC_SEL_RXBOTH     4'h6
`define IASC_SEL_CSI        4'h7
`define IASC_BIST_MODE_HI   7
`define IASC_BIST_MODE_LO   6
`define IASC_BIST_PIN       3
`define IASC_BIST_CS_HI     2
`define IASC_BIST_CS_LO     1
`define IASC_BIST_EN        0
`define IASC_OUT_DIS        2'b00
`define IASC_OUT_EN         2'b10
`define IASC_SER_CS_OFS     8'h14
`define IASC_TGT_N          5
`define IASC_RD_WAIT        2'd2
`endif

// ===== design/iasc_target_port.v
// indirect target strobe generator with read wait counter
`timescale 1ns/1ps
`include "iasc_consts.vh"
module iasc_target_port (
  input  wire       CLOCK,
  input  wire       SYS_RST,
  input  wire [3:0] sel,
  input  wire       wr_go,
  input  wire       rd_go,
  output reg  [4:0] wr_stb_reg,
  output reg  [4:0] rd_stb_reg,
  output reg        rd_done_reg,
  output reg        busy_reg
);
  reg [1:0] wait_reg;
  reg [4:0] dec;
  // one-hot block decode except code 6 writes, which strobe both rx blocks; reserved codes reach no block
  function [4:0] tgt_dec;
    input [3:0] s;
    input       wr;
    begin
      tgt_dec = 5'h00;
      if (s == `IASC_SEL_PATGEN) tgt_dec = 5'h01;
      else if (s == `IASC_SEL_RX0) tgt_dec = 5'h02;
      else if (s == `IASC_SEL_RX1) tgt_dec = 5'h04;
      else if (s == `IASC_SEL_RXSH) tgt_dec = 5'h08;
      else if (s == `IASC_SEL_CSI) tgt_dec = 5'h10;
      else if (s == `IASC_SEL_RXBOTH && wr) tgt_dec = 5'h06;
    end
  endfunction
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      wr_stb_reg  <= 5'h00;
      rd_stb_reg  <= 5'h00;
      rd_done_reg <= 1'b0;
      busy_reg    <= 1'b0;
      wait_reg    <= 2'd0;
    end else begin
      wr_stb_reg  <= wr_go ? tgt_dec(sel, 1'b1) : 5'h00;
      rd_stb_reg  <= rd_go ? tgt_dec(sel, 1'b0) : 5'h00;
      rd_done_reg <= 1'b0;
      if (rd_go) begin
        busy_reg <= 1'b1;
        wait_reg <= `IASC_RD_WAIT;
      end else if (busy_reg) begin
        // targets return data a fixed time after the strobe
        if (wait_reg == 2'd0) begin
          busy_reg    <= 1'b0;
          rd_done_reg <= 1'b1;
        end else begin
          wait_reg <= wait_reg - 2'd1;
        end
      end
    end
  end
endmodule // iasc_target_port

// ===== design/iasc_top.v
// ahb-lite register bank for indirect access and self-test control
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "iasc_consts.vh"
// Summary of operation
// - codes 0,5,7 pick patgen, shared, csi
// - codes 1 and 2 pick rx ports
// - code 6 writes both rx ports
// - auto-increment bumps offset after access
// - prefetch: offset write issues read strobe
// - prefetch plus increment: data read restrobes
// - offset register is eight bits
// - data write writes target at offset
// - data read returns target register value
// - output mode 00 disables, 10 enables
// - pin bit picks pin or register config
// - enable copies clock source to serializer
// - bit zero enables self-test, resets zero
module iasc_top (
  input  wire        CLOCK,
  input  wire        SYS_RST,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  output reg  [7:0]  TGT_OFFSET,
  output reg  [7:0]  TGT_WDATA,
  output reg  [4:0]  TGT_WR_STB,
  output reg  [4:0]  TGT_RD_STB,
  input  wire [39:0] TGT_RDATA,
  input  wire        BIST_PIN_EN,
  input  wire [1:0]  BIST_PIN_CS,
  output reg         BIST_ACTIVE,
  output reg         BIST_OUT_ENABLE,
  output reg         SER_WR_STB,
  output reg  [7:0]  SER_WR_OFFSET,
  output reg  [1:0]  SER_CLK_SRC
);
  localparam ST_IDLE = 3'b001;
  localparam ST_DATA = 3'b010;
  localparam ST_WAIT = 3'b100;
  reg  [2:0]  state_reg;
  reg  [7:0]  ctl_reg;
  reg  [7:0]  ofs_reg;
  reg  [7:0]  data_reg;
  reg  [7:0]  bist_reg;
  reg  [7:0]  sp4_reg;
  reg  [7:0]  sp5_reg;
  reg  [7:0]  sp6_reg;
  reg  [7:0]  sp7_reg;
  reg  [7:0]  idx_reg;
  reg         wr_reg;
  reg         wr_go_reg;
  reg         rd_go_reg;
  reg         inc_pend_reg;
  reg         rd_inc_reg;
  reg         pin_en_m;
  reg         pin_en_s;
  reg  [1:0]  pin_cs_m;
  reg  [1:0]  pin_cs_s;
  reg         bist_en_d;
  reg  [7:0]  rd_mux;
  reg  [7:0]  tgt_val;
  wire [4:0]  wr_stb;
  wire [4:0]  rd_stb;
  wire        rd_done;
  wire        busy;
  wire [3:0]  sel = ctl_reg[`IASC_CTL_SEL_HI:`IASC_CTL_SEL_LO];
  wire        ainc = ctl_reg[`IASC_CTL_AINC];
  wire        pref = ctl_reg[`IASC_CTL_PREF];
  wire        addr_ok = HSEL && HREADY && HTRANS[1];
  wire [7:0]  widx = HADDR[9:2];
  wire [7:0]  wdat = HWDATA[7:0];
  wire        bist_en;
  wire [1:0]  bist_cs;
  iasc_target_port u_port (
    .CLOCK       (CLOCK),
    .SYS_RST     (SYS_RST),
    .sel         (sel),
    .wr_go       (wr_go_reg),
    .rd_go       (rd_go_reg),
    .wr_stb_reg  (wr_stb),
    .rd_stb_reg  (rd_stb),
    .rd_done_reg (rd_done),
    .busy_reg    (busy)
  );
  // pin straps cross from outside, two flops first
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      pin_en_m <= 1'b0;
      pin_en_s <= 1'b0;
      pin_cs_m <= 2'b00;
      pin_cs_s <= 2'b00;
    end else begin
      pin_en_m <= BIST_PIN_EN;
      pin_en_s <= pin_en_m;
      pin_cs_m <= BIST_PIN_CS;
      pin_cs_s <= pin_cs_m;
    end
  end
  assign bist_en = bist_reg[`IASC_BIST_PIN] ? pin_en_s : bist_reg[`IASC_BIST_EN];
  assign bist_cs = bist_reg[`IASC_BIST_PIN] ? pin_cs_s :
                   bist_reg[`IASC_BIST_CS_HI:`IASC_BIST_CS_LO];
  // reading picks the selected block's byte; reserved codes read zero
  always @* begin
    tgt_val = 8'h00;
    if (sel == `IASC_SEL_PATGEN) tgt_val = TGT_RDATA[7:0];
    else if (sel == `IASC_SEL_RX0) tgt_val = TGT_RDATA[15:8];
    else if (sel == `IASC_SEL_RX1) tgt_val = TGT_RDATA[23:16];
    else if (sel == `IASC_SEL_RXSH) tgt_val = TGT_RDATA[31:24];
    else if (sel == `IASC_SEL_CSI) tgt_val = TGT_RDATA[39:32];
  end
  always @* begin
    rd_mux = 8'h00;
    if (idx_reg == `IASC_IDX_CTL) rd_mux = ctl_reg & `IASC_CTL_MASK;
    else if (idx_reg == `IASC_IDX_OFS) rd_mux = ofs_reg;
    else if (idx_reg == `IASC_IDX_DATA) rd_mux = data_reg;
    else if (idx_reg == `IASC_IDX_BIST) rd_mux = bist_reg;
    else if (idx_reg == `IASC_IDX_SP4) rd_mux = sp4_reg;
    else if (idx_reg == `IASC_IDX_SP5) rd_mux = sp5_reg;
    else if (idx_reg == `IASC_IDX_SP6) rd_mux = sp6_reg;
    else if (idx_reg == `IASC_IDX_SP7) rd_mux = sp7_reg;
    else if (idx_reg == `IASC_IDX_STS) rd_mux = {6'h00, BIST_ACTIVE, busy};
  end
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      state_reg    <= ST_IDLE;
      ctl_reg      <= `IASC_RST_CTL;
      ofs_reg      <= `IASC_RST_OFS;
      data_reg     <= `IASC_RST_DATA;
      bist_reg     <= `IASC_RST_BIST;
      sp4_reg      <= `IASC_RST_SP4;
      sp5_reg      <= `IASC_RST_SP5;
      sp6_reg      <= `IASC_RST_SP6;
      sp7_reg      <= `IASC_RST_SP7;
      idx_reg      <= 8'h00;
      wr_reg       <= 1'b0;
      wr_go_reg    <= 1'b0;
      rd_go_reg    <= 1'b0;
      inc_pend_reg <= 1'b0;
      rd_inc_reg   <= 1'b0;
      HRDATA       <= 32'h0000_0000;
      HREADYOUT    <= 1'b1;
      HRESP        <= 1'b0;
    end else begin
      wr_go_reg <= 1'b0;
      rd_go_reg <= 1'b0;
      HRESP     <= 1'b0;
      // offset advances only once the write strobe has left, so the write keeps the old offset
      if (inc_pend_reg && !wr_go_reg && wr_stb == 5'h00) begin
        inc_pend_reg <= 1'b0;
        ofs_reg      <= ofs_reg + 8'h01;
      end
      if (rd_inc_reg && !busy && !rd_go_reg) begin
        rd_inc_reg <= 1'b0;
        ofs_reg    <= ofs_reg + 8'h01;
        if (pref) rd_go_reg <= 1'b1;
      end
      if (rd_done) data_reg <= tgt_val;
      case (state_reg)
        ST_IDLE: begin
          if (addr_ok) begin
            idx_reg   <= widx;
            wr_reg    <= HWRITE;
            state_reg <= ST_DATA;
            // a data read with no prefetch fetches now and stalls
            if (!HWRITE && widx == `IASC_IDX_DATA && !pref) begin
              rd_go_reg <= 1'b1;
              HREADYOUT <= 1'b0;
              state_reg <= ST_WAIT;
            end else if (busy || rd_inc_reg || inc_pend_reg) begin
              HREADYOUT <= 1'b0;
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (!busy && !rd_go_reg && !rd_done && !rd_inc_reg && !inc_pend_reg) begin
            HREADYOUT <= 1'b1;
            HRDATA    <= {24'h000000, rd_mux};
            state_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          state_reg <= ST_IDLE;
          if (wr_reg) begin
            if (idx_reg == `IASC_IDX_CTL) ctl_reg <= wdat & `IASC_CTL_MASK;
            else if (idx_reg == `IASC_IDX_OFS) begin
              ofs_reg <= wdat;
              if (pref) rd_go_reg <= 1'b1;
            end else if (idx_reg == `IASC_IDX_DATA) begin
              data_reg  <= wdat;
              wr_go_reg <= 1'b1;
              if (ainc) inc_pend_reg <= 1'b1;
            end else if (idx_reg == `IASC_IDX_BIST) bist_reg <= wdat;
            else if (idx_reg == `IASC_IDX_SP4) sp4_reg <= wdat;
            else if (idx_reg == `IASC_IDX_SP5) sp5_reg <= wdat;
            else if (idx_reg == `IASC_IDX_SP6) sp6_reg <= wdat;
            else if (idx_reg == `IASC_IDX_SP7) sp7_reg <= wdat;
          end else if (idx_reg == `IASC_IDX_DATA && ainc) begin
            rd_inc_reg <= 1'b1;
          end
          if (!wr_reg && HREADYOUT) HRDATA <= HRDATA;
          if (addr_ok) begin
            idx_reg   <= widx;
            wr_reg    <= HWRITE;
            state_reg <= ST_DATA;
            if (!HWRITE && widx == `IASC_IDX_DATA && !pref) begin
              rd_go_reg <= 1'b1;
              HREADYOUT <= 1'b0;
              state_reg <= ST_WAIT;
            end else begin
              HREADYOUT <= 1'b0;
              state_reg <= ST_WAIT;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (state_reg == ST_IDLE && addr_ok && !(busy || rd_inc_reg || inc_pend_reg) &&
          !(!HWRITE && widx == `IASC_IDX_DATA && !pref)) begin
        HRDATA <= 32'h0000_0000;
        HREADYOUT <= 1'b0;
        state_reg <= ST_WAIT;
      end
    end
  end
  // target-side and self-test outputs, all registered
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      TGT_OFFSET      <= 8'h00;
      TGT_WDATA       <= 8'h00;
      TGT_WR_STB      <= 5'h00;
      TGT_RD_STB      <= 5'h00;
      BIST_ACTIVE     <= 1'b0;
      BIST_OUT_ENABLE <= 1'b0;
      SER_WR_STB      <= 1'b0;
      SER_WR_OFFSET   <= `IASC_SER_CS_OFS;
      SER_CLK_SRC     <= 2'b00;
      bist_en_d       <= 1'b0;
    end else begin
      TGT_OFFSET  <= ofs_reg;
      TGT_WDATA   <= data_reg;
      TGT_WR_STB  <= wr_stb;
      TGT_RD_STB  <= rd_stb;
      bist_en_d   <= bist_en;
      BIST_ACTIVE <= bist_en;
      // reserved modes fall back to outputs disabled
      BIST_OUT_ENABLE <= bist_en &&
        (bist_reg[`IASC_BIST_MODE_HI:`IASC_BIST_MODE_LO] == `IASC_OUT_EN);
      SER_WR_STB  <= bist_en && !bist_en_d;
      SER_WR_OFFSET <= `IASC_SER_CS_OFS;
      if (bist_en && !bist_en_d) SER_CLK_SRC <= bist_cs;
    end
  end
endmodule // iasc_top

// ===== testbench/iasc_checker.sv
// port assertions for the indirect access and self-test block
`timescale 1ns/1ps
module iasc_checker (
  input logic       CLOCK,
  input logic       SYS_RST,
  input logic       HSEL,
  input logic [1:0] HTRANS,
  input logic       HREADY,
  input logic       HREADYOUT,
  input logic       HRESP,
  input logic [7:0] TGT_OFFSET,
  input logic [4:0] TGT_WR_STB,
  input logic [4:0] TGT_RD_STB,
  input logic       BIST_ACTIVE,
  input logic       BIST_OUT_ENABLE,
  input logic       SER_WR_STB,
  input logic [7:0] SER_WR_OFFSET
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_addr; HSEL && HREADY && HTRANS[1]; endsequence
  sequence s_stall; !HREADYOUT ##[1:20] HREADYOUT; endsequence
  property p_addr_stall; s_addr |=> s_stall; endproperty
  a_addr_stall: assert property (p_addr_stall)
    else $error("no bounded wait state after address phase");
  property p_okay; HRESP == 1'b0; endproperty
  a_okay: assert property (p_okay)
    else $error("error response seen");
  property p_wr_dec;
    TGT_WR_STB != 5'h00 |-> TGT_WR_STB inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h06};
  endproperty
  a_wr_dec: assert property (p_wr_dec)
    else $error("bad write strobe decode");
  property p_rd_dec; TGT_RD_STB inside {5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10}; endproperty
  a_rd_dec: assert property (p_rd_dec)
    else $error("bad read strobe decode");
  property p_wr_pulse; TGT_WR_STB != 5'h00 |=> TGT_WR_STB == 5'h00; endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  // offset must not move while the fetched byte is still being captured
  property p_rd_hold; TGT_RD_STB != 5'h00 |=> $stable(TGT_OFFSET) [*2]; endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("offset moved during fetch");
  property p_ser_ofs; SER_WR_STB |-> SER_WR_OFFSET == 8'h14 ##1 !SER_WR_STB; endproperty
  a_ser_ofs: assert property (p_ser_ofs)
    else $error("serializer write wrong offset or too long");
  property p_out_en; BIST_OUT_ENABLE |-> BIST_ACTIVE; endproperty
  a_out_en: assert property (p_out_en)
    else $error("outputs enabled outside self-test");
endmodule // iasc_checker
bind iasc_top iasc_checker i_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .HSEL(HSEL),
  .HTRANS(HTRANS), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .TGT_OFFSET(TGT_OFFSET), .TGT_WR_STB(TGT_WR_STB), .TGT_RD_STB(TGT_RD_STB),
  .BIST_ACTIVE(BIST_ACTIVE), .BIST_OUT_ENABLE(BIST_OUT_ENABLE),
  .SER_WR_STB(SER_WR_STB), .SER_WR_OFFSET(SER_WR_OFFSET));

// ===== testbench/iasc_tgt_model.sv
// behavioural model of the five indirect target register blocks
`timescale 1ns/1ps
module iasc_tgt_model (
  input  logic        CLOCK,
  input  logic [7:0]  TGT_OFFSET,
  input  logic [7:0]  TGT_WDATA,
  input  logic [4:0]  TGT_WR_STB,
  input  logic [4:0]  TGT_RD_STB,
  output logic [39:0] TGT_RDATA
);
  logic [7:0] mem [0:4][0:255];
  int         age = 0;
  initial begin
    TGT_RDATA = 40'h0;
    foreach (mem[i, j]) mem[i][j] = 8'h00;
  end
  // a fetched byte holds five cycles, then scrambles so a late sample shows up
  always @(posedge CLOCK) begin
    age <= (TGT_RD_STB != 5'h00) ? 0 : age + 1;
    if (age >= 4) TGT_RDATA <= ~TGT_RDATA;
    for (int i = 0; i < 5; i++) begin
      if (TGT_WR_STB[i]) mem[i][TGT_OFFSET] <= TGT_WDATA;
      if (TGT_RD_STB[i]) TGT_RDATA[i*8 +: 8] <= mem[i][TGT_OFFSET];
    end
  end
endmodule // iasc_tgt_model

// ===== testbench/iasc_top_tb.sv
// self-checking bench for the indirect access and self-test block
`timescale 1ns/1ps
`include "iasc_consts.vh"
module iasc_top_tb;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, pin_en = 1'b0;
  logic [1:0]  htrans = 2'b00, pin_cs = 2'b00, ser_cs;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        hready, hresp, act, oen, ser_stb;
  logic [7:0]  tofs, twd, ser_ofs, rv;
  logic [4:0]  twr, trd;
  logic [39:0] trdata;
  logic [3:0]  codes [5] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h7};
  logic [7:0]  rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h25, 8'h00, 8'h18, 8'h00};
  int          miscompares = 0, tests_run = 0, ser_cnt = 0, rd_cnt = 0, n;
  always #12.5 clk = ~clk;
  iasc_top i_dut (.CLOCK(clk), .SYS_RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(hresp), .TGT_OFFSET(tofs), .TGT_WDATA(twd),
    .TGT_WR_STB(twr), .TGT_RD_STB(trd), .TGT_RDATA(trdata), .BIST_PIN_EN(pin_en),
    .BIST_PIN_CS(pin_cs), .BIST_ACTIVE(act), .BIST_OUT_ENABLE(oen),
    .SER_WR_STB(ser_stb), .SER_WR_OFFSET(ser_ofs), .SER_CLK_SRC(ser_cs));
  iasc_tgt_model i_mdl (.CLOCK(clk), .TGT_OFFSET(tofs), .TGT_WDATA(twd),
    .TGT_WR_STB(twr), .TGT_RD_STB(trd), .TGT_RDATA(trdata));
  always @(posedge clk) begin
    if (ser_stb === 1'b1) ser_cnt++;
    if (trd[0] === 1'b1) rd_cnt++;
  end
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rv = hrdata[7:0];
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk(rv, exp);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rst_tab[i]) rdchk(8'hb0 + 8'(i), rst_tab[i]);
    rdchk(8'hb8, 8'h00);
    rdchk(8'hc0, 8'h00);
    bus(`IASC_IDX_CTL, 1'b1, 8'hff);
    rdchk(`IASC_IDX_CTL, 8'h3f);
    $display("test reset and access done");
    foreach (codes[i]) begin
      bus(`IASC_IDX_CTL, 1'b1, {2'b00, codes[i], 2'b10});
      bus(`IASC_IDX_OFS, 1'b1, 8'hfe);
      bus(`IASC_IDX_DATA, 1'b1, {codes[i], 4'h1});
      bus(`IASC_IDX_DATA, 1'b1, {codes[i], 4'h2});
      rdchk(`IASC_IDX_OFS, 8'h00);
    end
    foreach (codes[i]) begin
      chk(i_mdl.mem[i][8'hfe], {codes[i], 4'h1});
      bus(`IASC_IDX_CTL, 1'b1, {2'b00, codes[i], 2'b10});
      bus(`IASC_IDX_OFS, 1'b1, 8'hfe);
      rdchk(`IASC_IDX_DATA, {codes[i], 4'h1});
      rdchk(`IASC_IDX_DATA, {codes[i], 4'h2});
    end
    bus(`IASC_IDX_CTL, 1'b1, 8'h18);
    bus(`IASC_IDX_OFS, 1'b1, 8'h40);
    bus(`IASC_IDX_DATA, 1'b1, 8'h6c);
    repeat (6) @(posedge clk);
    chk(i_mdl.mem[1][8'h40], 8'h6c);
    chk(i_mdl.mem[2][8'h40], 8'h6c);
    $display("test routing and increment done");
    bus(`IASC_IDX_CTL, 1'b1, 8'h03);
    n = rd_cnt;
    bus(`IASC_IDX_OFS, 1'b1, 8'hfe);
    repeat (8) @(posedge clk);
    chk(8'(rd_cnt - n), 8'h01);
    rdchk(`IASC_IDX_DATA, 8'h01);
    rdchk(`IASC_IDX_DATA, 8'h02);
    repeat (8) @(posedge clk);
    chk(8'(rd_cnt - n), 8'h03);
    rdchk(`IASC_IDX_OFS, 8'h00);
    $display("test prefetch done");
    n = ser_cnt;
    bus(`IASC_IDX_BIST, 1'b1, 8'h85);
    repeat (3) @(posedge clk);
    chk({7'h0, act}, 8'h01);
    chk({7'h0, oen}, 8'h01);
    chk({6'h0, ser_cs}, 8'h02);
    chk(8'(ser_cnt - n), 8'h01);
    chk(ser_ofs, 8'h14);
    rdchk(`IASC_IDX_BIST, 8'h85);
    bus(`IASC_IDX_BIST, 1'b1, 8'h00);
    repeat (3) @(posedge clk);
    chk({7'h0, act}, 8'h00);
    bus(`IASC_IDX_BIST, 1'b1, 8'h03);
    repeat (3) @(posedge clk);
    chk({7'h0, oen}, 8'h00);
    chk({6'h0, ser_cs}, 8'h01);
    bus(`IASC_IDX_BIST, 1'b1, 8'h08);
    pin_en <= 1'b1;
    pin_cs <= 2'b10;
    repeat (6) @(posedge clk);
    chk({7'h0, act}, 8'h01);
    chk({6'h0, ser_cs}, 8'h02);
    pin_en <= 1'b0;
    repeat (6) @(posedge clk);
    chk({7'h0, act}, 8'h00);
    $display("test self-test control done");
    end_sim;
  end
  // the whole sequence needs well under a thousand cycles, so this only trips on a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim;
  end
endmodule // iasc_top_tb
